// ### dbc_regs.svh
// Command codes, field positions, reset values and counts for the debug unit
`ifndef DBC_REGS_SVH
`define DBC_REGS_SVH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define DBC_CMD_MASS_ERASE   8'h14
`define DBC_CMD_CFG_WRITE    8'h1D
`define DBC_CMD_CFG_READ     8'h24
`define DBC_CMD_PC_FETCH     8'h28
`define DBC_CMD_STATUS_READ  8'h34
`define DBC_CMD_BP_SET       8'h3B
`define DBC_CMD_HALT         8'h44
`define DBC_CMD_RESUME       8'h4C
`define DBC_CMD_INJECT_HI    6'h15
`define DBC_CMD_STEP         8'h5C
`define DBC_CMD_REPLACE_HI   6'h19
`define DBC_CMD_IDENT_READ   8'h68

// ------------------------------------------------------------
// Breakpoint operand fields
// ------------------------------------------------------------
`define DBC_BP_SLOT_HI       4
`define DBC_BP_SLOT_LO       3
`define DBC_BP_ENABLE_BIT    2
`define DBC_BP_SLOTS         4

// ------------------------------------------------------------
// Status byte fields
// ------------------------------------------------------------
`define DBC_ST_ERASE_DONE    7
`define DBC_ST_CPU_IDLE      6
`define DBC_ST_CPU_HALTED    5
`define DBC_ST_POWER_MODE0   4
`define DBC_ST_HALT_CAUSE    3
`define DBC_ST_DEBUG_LOCK    2

// ------------------------------------------------------------
// Reset values, identity and last receive bit index
// ------------------------------------------------------------
`define DBC_CFG_RESET        8'h00
`define DBC_PART_NUMBER      8'h5A
`define DBC_REVISION         8'h03
`define DBC_BITS_PER_BYTE    3'h7

`endif

// ### dbc_pkg.sv
// Types shared by the debug command unit
package dbc_pkg;

    typedef logic [7:0] dbc_byte_t;

    typedef enum logic [3:0] {
        DBC_ST_COMMAND = 4'b0001,
        DBC_ST_OPERAND = 4'b0010,
        DBC_ST_EXECUTE = 4'b0100,
        DBC_ST_REPLY   = 4'b1000
    } dbc_state_e;

endpackage

// ### dbc_debug_unit.sv
// Debug command decoder and hardware breakpoint unit behind a serial link
//
// Overview of operation
// - Four breakpoint slots: address plus enable
// - Enabled slot matching code address halts CPU
// - Operand one: slot bits 4:3, enable bit 2
// - Operands two, three: address high, low
// - Mass erase command starts erase, returns status
// - Configuration write stores byte, returns status
// - Configuration read returns last stored byte
// - Program counter fetch returns 16-bit PC
// - Status read returns debug status byte
// - Halt stops CPU, returns status
// - Resume restarts CPU, returns status
// - Injection runs host instruction, PC unchanged
// - Low two code bits give instruction length
// - Single step runs next instruction, advances PC
// - Step replace runs host instruction, advances PC
// - Identity read returns part number, revision
// - Link bytes travel MSB first, one to four
// - Locked unit runs only three commands; CPU control codes still refresh lock, inject/replace still load cpu_instr
// - Status bit 7 low while erase runs
`timescale 1ns/1ps
`include "dbc_regs.svh"

module dbc_debug_unit (
    input  wire logic        clock,
    input  wire logic        srst,
    // Serial debug link
    input  wire logic        dbg_clk,
    input  wire logic        dbg_data_in,
    output logic             dbg_data_out,
    output logic             dbg_data_oe_n,
    // CPU side
    input  wire logic [15:0] cpu_code_addr,
    input  wire logic [15:0] cpu_pc,
    input  wire logic        cpu_halted,
    input  wire logic        cpu_idle,
    input  wire logic        power_mode0,
    output logic             cpu_halt,
    output logic             cpu_step,
    output logic             cpu_inject,
    output logic             cpu_replace,
    output logic [1:0]       cpu_instr_len,
    output logic [23:0]      cpu_instr,
    // Flash and lock
    input  wire logic        erase_busy,
    input  wire logic        debug_lock_bit,
    output logic             erase_start,
    output logic [7:0]       debug_config
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] operand_count(input logic [7:0] code);
        if (code == `DBC_CMD_BP_SET)
            operand_count = 2'd3;
        else if (code == `DBC_CMD_CFG_WRITE)
            operand_count = 2'd1;
        else if (code[7:2] == `DBC_CMD_INJECT_HI ||
                 code[7:2] == `DBC_CMD_REPLACE_HI)
            operand_count = code[1:0];
        else
            operand_count = 2'd0;
    endfunction

    function automatic logic allowed_when_locked(input logic [7:0] code);
        allowed_when_locked = (code == `DBC_CMD_MASS_ERASE) ||
                              (code == `DBC_CMD_STATUS_READ) ||
                              (code == `DBC_CMD_IDENT_READ);
    endfunction

    // ------------------------------------------------------------
    // Link synchronisers and edge detection
    // ------------------------------------------------------------
    logic [2:0] clk_sync;
    logic [1:0] din_sync;
    logic       link_rise;

    always_ff @(posedge clock) begin
        if (srst) begin
            clk_sync <= 3'b000;
            din_sync <= 2'b00;
        end else begin
            clk_sync <= {clk_sync[1:0], dbg_clk};
            din_sync <= {din_sync[0], dbg_data_in};
        end
    end

    assign link_rise = clk_sync[1] & ~clk_sync[2];

    // ------------------------------------------------------------
    // Byte receiver
    // ------------------------------------------------------------
    dbc_pkg::dbc_state_e state;
    dbc_pkg::dbc_byte_t  rx_shift;
    logic [2:0]          rx_bits;
    logic                byte_done;
    dbc_pkg::dbc_byte_t  rx_byte;

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_shift  <= 8'h00;
            rx_bits   <= 3'h0;
            byte_done <= 1'b0;
            rx_byte   <= 8'h00;
        end else begin
            byte_done <= 1'b0;
            if (link_rise && state != dbc_pkg::DBC_ST_REPLY) begin
                rx_shift <= {rx_shift[6:0], din_sync[1]};
                rx_bits  <= rx_bits + 3'h1;
                if (rx_bits == `DBC_BITS_PER_BYTE) begin
                    byte_done <= 1'b1;
                    rx_byte   <= {rx_shift[6:0], din_sync[1]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Command framing
    // ------------------------------------------------------------
    dbc_pkg::dbc_byte_t command;
    logic [1:0]         ops_left;
    logic [1:0]         op_index;
    dbc_pkg::dbc_byte_t operand [0:2];
    logic               reply_done;
    logic [1:0]         reply_len;

    always_ff @(posedge clock) begin
        if (srst) begin
            state    <= dbc_pkg::DBC_ST_COMMAND;
            command  <= 8'h00;
            ops_left <= 2'd0;
            op_index <= 2'd0;
            for (int i = 0; i < 3; i++) begin
                operand[i] <= 8'h00;
            end
        end else begin
            case (state)
                dbc_pkg::DBC_ST_COMMAND: begin
                    if (byte_done) begin
                        command  <= rx_byte;
                        op_index <= 2'd0;
                        ops_left <= operand_count(rx_byte);
                        if (operand_count(rx_byte) == 2'd0)
                            state <= dbc_pkg::DBC_ST_EXECUTE;
                        else
                            state <= dbc_pkg::DBC_ST_OPERAND;
                    end
                end
                dbc_pkg::DBC_ST_OPERAND: begin
                    if (byte_done) begin
                        operand[op_index] <= rx_byte;
                        op_index <= op_index + 2'd1;
                        ops_left <= ops_left - 2'd1;
                        if (ops_left == 2'd1)
                            state <= dbc_pkg::DBC_ST_EXECUTE;
                    end
                end
                dbc_pkg::DBC_ST_EXECUTE: begin
                    if (reply_len != 2'd0)
                        state <= dbc_pkg::DBC_ST_REPLY;
                    else
                        state <= dbc_pkg::DBC_ST_COMMAND;
                end
                dbc_pkg::DBC_ST_REPLY: begin
                    if (reply_done)
                        state <= dbc_pkg::DBC_ST_COMMAND;
                end
                default: begin
                    state <= dbc_pkg::DBC_ST_COMMAND;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command execution
    // ------------------------------------------------------------
    logic       exec;
    logic       enabled;
    logic       lock_seen;
    logic       halt_by_bp;
    logic       bp_hit;
    logic [15:0] reply_word;
    logic [7:0] status_byte;
    logic       is_inject;
    logic       is_replace;

    assign exec       = (state == dbc_pkg::DBC_ST_EXECUTE);
    // Operands are always consumed so a locked command keeps framing
    assign enabled    = lock_seen | allowed_when_locked(command);
    assign is_inject  = command[7:2] == `DBC_CMD_INJECT_HI;
    assign is_replace = command[7:2] == `DBC_CMD_REPLACE_HI;

    always_comb begin
        status_byte = 8'h00;
        status_byte[`DBC_ST_ERASE_DONE] = ~erase_busy;
        status_byte[`DBC_ST_CPU_IDLE]   = cpu_idle;
        status_byte[`DBC_ST_CPU_HALTED] = cpu_halted;
        status_byte[`DBC_ST_POWER_MODE0] = power_mode0;
        status_byte[`DBC_ST_HALT_CAUSE] = halt_by_bp;
        status_byte[`DBC_ST_DEBUG_LOCK] = lock_seen;
    end

    always_comb begin
        reply_len  = 2'd0;
        reply_word = 16'h0000;
        if (enabled) begin
            case (command)
                `DBC_CMD_CFG_READ: begin
                    reply_len  = 2'd1;
                    reply_word = {debug_config, 8'h00};
                end
                `DBC_CMD_PC_FETCH: begin
                    reply_len  = 2'd2;
                    reply_word = cpu_pc;
                end
                `DBC_CMD_IDENT_READ: begin
                    reply_len  = 2'd2;
                    reply_word = {`DBC_PART_NUMBER, `DBC_REVISION};
                end
                `DBC_CMD_BP_SET: begin
                    reply_len  = 2'd0;
                end
                default: begin
                    // Every other command answers with one status byte
                    reply_len  = 2'd1;
                    reply_word = {status_byte, 8'h00};
                end
            endcase
        end
    end

    // Lock value is refreshed on reset and on CPU control commands
    always_ff @(posedge clock) begin
        if (srst) begin
            lock_seen <= debug_lock_bit;
        end else if (exec && (command == `DBC_CMD_HALT ||
                              command == `DBC_CMD_RESUME ||
                              command == `DBC_CMD_STEP ||
                              is_inject || is_replace)) begin
            lock_seen <= debug_lock_bit;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            debug_config <= `DBC_CFG_RESET;
            erase_start  <= 1'b0;
        end else begin
            erase_start <= exec && enabled &&
                           command == `DBC_CMD_MASS_ERASE;
            if (exec && enabled && command == `DBC_CMD_CFG_WRITE)
                debug_config <= operand[0];
        end
    end

    // ------------------------------------------------------------
    // Breakpoints
    // ------------------------------------------------------------
    logic [15:0] bp_addr   [0:`DBC_BP_SLOTS-1];
    logic        bp_enable [0:`DBC_BP_SLOTS-1];
    logic [`DBC_BP_SLOTS-1:0] bp_match;

    genvar g;
    generate
        for (g = 0; g < `DBC_BP_SLOTS; g++) begin : gen_slot
            always_ff @(posedge clock) begin
                if (srst) begin
                    bp_addr[g]   <= 16'h0000;
                    bp_enable[g] <= 1'b0;
                end else if (exec && enabled &&
                             command == `DBC_CMD_BP_SET &&
                             operand[0][`DBC_BP_SLOT_HI:`DBC_BP_SLOT_LO]
                                 == 2'(g)) begin
                    bp_enable[g] <= operand[0][`DBC_BP_ENABLE_BIT];
                    bp_addr[g]   <= {operand[1], operand[2]};
                end
            end
            assign bp_match[g] = bp_enable[g] &&
                                 bp_addr[g] == cpu_code_addr;
        end
    endgenerate

    assign bp_hit = |bp_match;

    // ------------------------------------------------------------
    // CPU control
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            cpu_halt   <= 1'b0;
            halt_by_bp <= 1'b0;
        end else if (bp_hit && !cpu_halt) begin
            cpu_halt   <= 1'b1;
            halt_by_bp <= 1'b1;
        end else if (exec && enabled && command == `DBC_CMD_HALT) begin
            cpu_halt   <= 1'b1;
            halt_by_bp <= 1'b0;
        end else if (exec && enabled && command == `DBC_CMD_RESUME) begin
            cpu_halt   <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cpu_step      <= 1'b0;
            cpu_inject    <= 1'b0;
            cpu_replace   <= 1'b0;
            cpu_instr_len <= 2'd0;
            cpu_instr     <= 24'h00_0000;
        end else begin
            cpu_step    <= exec && enabled &&
                           command == `DBC_CMD_STEP;
            cpu_inject  <= exec && enabled && is_inject;
            cpu_replace <= exec && enabled && is_replace;
            if (exec && (is_inject || is_replace)) begin
                cpu_instr_len <= command[1:0];
                cpu_instr     <= {operand[0], operand[1], operand[2]};
            end
        end
    end

    // ------------------------------------------------------------
    // Reply shifter: host samples on rising edge, unit moves on after it
    // ------------------------------------------------------------
    logic [15:0] tx_shift;
    logic [4:0]  tx_left;

    assign reply_done = (state == dbc_pkg::DBC_ST_REPLY) && link_rise &&
                        tx_left == 5'd1;

    always_ff @(posedge clock) begin
        if (srst) begin
            tx_shift      <= 16'h0000;
            tx_left       <= 5'd0;
            dbg_data_out  <= 1'b0;
            dbg_data_oe_n <= 1'b1;
        end else if (exec && reply_len != 2'd0) begin
            tx_shift      <= {reply_word[14:0], 1'b0};
            tx_left       <= (reply_len == 2'd2) ? 5'd16 : 5'd8;
            dbg_data_out  <= reply_word[15];
            dbg_data_oe_n <= 1'b0;
        end else if (state == dbc_pkg::DBC_ST_REPLY && link_rise) begin
            // The fall closing the command lands inside the reply, so
            // only a seen rise may move the next bit out
            tx_left      <= tx_left - 5'd1;
            dbg_data_out <= tx_shift[15];
            tx_shift     <= {tx_shift[14:0], 1'b0};
            if (tx_left == 5'd1)
                dbg_data_oe_n <= 1'b1;
        end
    end

endmodule

// ### dbc_debug_unit_props.sv
// Port-level concurrent checks for the debug command unit
`timescale 1ns/1ps

module dbc_checker (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       dbg_data_oe_n,
    input wire logic       cpu_halt,
    input wire logic       cpu_step,
    input wire logic       cpu_inject,
    input wire logic       cpu_replace,
    input wire logic       erase_start,
    input wire logic       debug_lock_bit,
    input wire logic [7:0] debug_config
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Refresh commands still reload the lock while locked; this copy keeps its reset value
    logic locked_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            locked_q <= !debug_lock_bit;
        end
    end

    sequence s_reply;
        ##[0:2] !dbg_data_oe_n;
    endsequence

    sequence s_reply_bits;
        !dbg_data_oe_n [*8];
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_erase_reply: assert property (erase_start |-> s_reply)
        else $error("no reply after erase start");
    a_erase_pulse: assert property (erase_start |=> !erase_start)
        else $error("erase start longer than one cycle");
    a_step_reply: assert property (cpu_step |-> s_reply)
        else $error("no reply after single step");
    a_inject_reply: assert property (cpu_inject |-> s_reply)
        else $error("no reply after injection");
    a_inject_alone: assert property (cpu_inject |-> !cpu_step && !cpu_replace)
        else $error("injection overlaps another cpu pulse");
    a_replace_reply: assert property (cpu_replace |-> s_reply)
        else $error("no reply after step replace");
    a_resume_reply: assert property ($fell(cpu_halt) |-> s_reply)
        else $error("halt released without reply");
    a_config_reply: assert property ($changed(debug_config) |-> s_reply)
        else $error("config changed without reply");
    a_reply_bits: assert property ($fell(dbg_data_oe_n) |-> s_reply_bits)
        else $error("reply drive dropped too early");
    a_locked_quiet: assert property (locked_q |-> !cpu_step && !cpu_inject && !cpu_replace)
        else $error("cpu pulse while locked");
    a_locked_config: assert property (locked_q |=> $stable(debug_config))
        else $error("config written while locked");
endmodule

bind dbc_debug_unit dbc_checker dbc_checker_inst (
    .clock(clock), .srst(srst), .dbg_data_oe_n(dbg_data_oe_n),
    .cpu_halt(cpu_halt), .cpu_step(cpu_step), .cpu_inject(cpu_inject),
    .cpu_replace(cpu_replace), .erase_start(erase_start),
    .debug_lock_bit(debug_lock_bit), .debug_config(debug_config));

// ### dbc_host_model.sv
// Behavioural debug host framing commands on the serial link
`timescale 1ns/1ps

module dbc_host_model (
    input  wire logic   clock,
    input  wire logic   line_in,
    output logic        dbg_clk,
    output logic        host_data,
    output logic [15:0] rx_data,
    output logic        rx_stb
);
    initial begin
        dbg_clk   = 1'b0;
        host_data = 1'b0;
        rx_data   = 16'h0000;
        rx_stb    = 1'b0;
    end

    // Half of the 80 ns link period, moved just after a clock edge
    task automatic half();
        repeat (10) @(posedge clock);
        #1;
    endtask

    // Link clock stands low outside frames
    task automatic xfer(input logic [7:0] tx[$], input int nrx);
        logic [15:0] r;
        r = 16'h0000;
        foreach (tx[i]) begin
            for (int b = 7; b >= 0; b--) begin
                host_data = tx[i][b];
                half();
                dbg_clk = 1'b1;
                half();
                dbg_clk = 1'b0;
            end
        end
        // Released line shows the inverse, never a stale level
        host_data = ~host_data;
        for (int b = 0; b < nrx; b++) begin
            half();
            r = {r[14:0], line_in};
            dbg_clk = 1'b1;
            half();
            dbg_clk = 1'b0;
        end
        if (nrx > 0) begin
            rx_data = r;
            rx_stb  = 1'b1;
            @(posedge clock);
            #1;
            rx_stb = 1'b0;
        end
        half();
    endtask
endmodule

// ### dbc_debug_unit_test.sv
// Self-checking bench for the debug command unit
`timescale 1ns/1ps
`include "dbc_regs.svh"

module dbc_debug_unit_test;
    logic        clock, srst, dbg_clk, dbg_data_in, dbg_data_out;
    logic        dbg_data_oe_n, host_data, rx_stb, cause;
    logic        cpu_halted, cpu_idle, power_mode0, erase_busy;
    logic        cpu_halt, cpu_step, cpu_inject, cpu_replace;
    logic        debug_lock_bit, erase_start;
    logic [1:0]  cpu_instr_len;
    logic [5:0]  pexp;
    logic [7:0]  debug_config, cfg;
    logic [7:0]  tx[$];
    logic [15:0] cpu_code_addr, cpu_pc, rx_data, bp;
    logic [15:0] exp_q[$];
    logic [5:0]  pq[$];
    logic [23:0] cpu_instr, instr, mask;
    string       nm_q[$];
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;

    dbc_debug_unit dbc_debug_unit_inst (
        .clock(clock), .srst(srst), .dbg_clk(dbg_clk),
        .dbg_data_in(dbg_data_in), .dbg_data_out(dbg_data_out),
        .dbg_data_oe_n(dbg_data_oe_n), .cpu_code_addr(cpu_code_addr),
        .cpu_pc(cpu_pc), .cpu_halted(cpu_halted), .cpu_idle(cpu_idle),
        .power_mode0(power_mode0), .cpu_halt(cpu_halt),
        .cpu_step(cpu_step), .cpu_inject(cpu_inject),
        .cpu_replace(cpu_replace), .cpu_instr_len(cpu_instr_len),
        .cpu_instr(cpu_instr), .erase_busy(erase_busy),
        .debug_lock_bit(debug_lock_bit), .erase_start(erase_start),
        .debug_config(debug_config));

    dbc_host_model dbc_host_model_inst (
        .clock(clock), .line_in(dbg_data_in), .dbg_clk(dbg_clk),
        .host_data(host_data), .rx_data(rx_data), .rx_stb(rx_stb));

    assign dbg_data_in = (dbg_data_oe_n === 1'b0) ? dbg_data_out : host_data;

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // CPU follows the halt request one cycle late
    always @(posedge clock) cpu_halted <= #1 cpu_halt;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(input string nm, input logic [23:0] seen,
                         input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [15:0] st(input logic lk);
        return {8'h00, ~erase_busy, cpu_idle, cpu_halted, power_mode0,
                cause, lk, 2'b00};
    endfunction

    task automatic cmd(input string nm, input logic [7:0] t[$],
                       input int nrx, input logic [15:0] e);
        if (nrx > 0) begin
            exp_q.push_back(e);
            nm_q.push_back(nm);
        end
        dbc_host_model_inst.xfer(t, nrx);
    endtask

    task automatic rst(input logic lk);
        srst = 1'b1;
        debug_lock_bit = lk;
        tick(10);
        srst = 1'b0;
        tick(2);
        cause = 1'b0;
        check("oe_n", 24'(dbg_data_oe_n), 24'h00_0001);
        check("config", 24'(debug_config), 24'(`DBC_CFG_RESET));
        check("halt", 24'(cpu_halt), 24'h00_0000);
        $display("reset test done");
    endtask

    // ----------------------------------------
    // Watchers
    // ----------------------------------------
    always @(posedge clock) begin
        if (rx_stb === 1'b1)
            check(nm_q.pop_front(), 24'(rx_data), 24'(exp_q.pop_front()));
        if ((erase_start | cpu_step | cpu_inject | cpu_replace) === 1'b1) begin
            pexp = (pq.size() > 0) ? pq.pop_front() : 6'h00;
            check("pulse", 24'({erase_start, cpu_step, cpu_inject, cpu_replace,
                  (cpu_inject | cpu_replace) ? cpu_instr_len : 2'b00}),
                  24'(pexp));
        end
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            conclude();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        cpu_code_addr = 16'hffff;
        cpu_halted = 1'b0;
        erase_busy = 1'b0;
        void'($urandom(73590));
        {cpu_idle, power_mode0} = 2'($urandom);
        cpu_pc = 16'($urandom);
        rst(1'b1);
        cmd("status", '{8'h34}, 8, st(1'b1));
        cmd("ident", '{8'h68}, 16, {`DBC_PART_NUMBER, `DBC_REVISION});
        cmd("pc", '{8'h28}, 16, cpu_pc);
        cfg = 8'($urandom);
        cmd("cfg_wr", '{8'h1d, cfg}, 8, st(1'b1));
        check("config", 24'(debug_config), 24'(cfg));
        cmd("cfg_rd", '{8'h24}, 8, 16'(cfg));
        $display("query test done");
        cmd("halt", '{8'h44}, 8, st(1'b1));
        check("halt", 24'(cpu_halt), 24'h00_0001);
        for (int k = 1; k < 4; k++) begin
            for (int m = 0; m < 2; m++) begin
                instr = 24'($urandom);
                tx = '{(m == 1 ? 8'h64 : 8'h54) | 8'(k)};
                for (int j = 0; j < k; j++) tx.push_back(instr[23-8*j -: 8]);
                pq.push_back({2'b00, 1'(m == 0), 1'(m == 1), 2'(k)});
                cmd("instr", tx, 8, st(1'b1));
                mask = ~(24'hff_ffff >> (8 * k));
                check("instr", cpu_instr & mask, instr & mask);
            end
        end
        pq.push_back(6'b01_0000);
        cmd("step", '{8'h5c}, 8, st(1'b1));
        cmd("resume", '{8'h4c}, 8, st(1'b1));
        check("resume", 24'(cpu_halt), 24'h00_0000);
        $display("cpu test done");
        for (int i = 0; i < 4; i++) begin
            bp = 16'h1230 + 16'(i);
            cmd("bp", '{8'h3b, {3'($urandom), 2'(i), 1'b1, 2'b00},
                bp[15:8], bp[7:0]}, 0, 16'h0000);
        end
        for (int i = 0; i < 5; i++) begin
            // Slot 0 goes off before the bus reaches its address again
            if (i == 4)
                cmd("bp_off", '{8'h3b, 8'h00, 8'h12, 8'h30}, 0, 16'h0000);
            cpu_code_addr = 16'h1230 + 16'(i % 4);
            tick(3);
            check("bp_halt", 24'(cpu_halt), 24'(i < 4));
            cpu_code_addr = 16'h1231;
            tick(3);
            check("bp_keep", 24'(cpu_halt), 24'h00_0001);
            cpu_code_addr = 16'hffff;
            cause = 1'b1;
            cmd("bp_status", '{8'h34}, 8, st(1'b1));
            cmd("resume", '{8'h4c}, 8, st(1'b1));
        end
        $display("breakpoint test done");
        pq.push_back(6'b10_0000);
        cmd("erase", '{8'h14}, 8, st(1'b1));
        erase_busy = 1'b1;
        cmd("erasing", '{8'h34}, 8, st(1'b1));
        erase_busy = 1'b0;
        cmd("erased", '{8'h34}, 8, st(1'b1));
        $display("erase test done");
        rst(1'b0);
        cmd("lk_halt", '{8'h44}, 0, 16'h0000);
        cmd("lk_cfg", '{8'h1d, 8'hff}, 0, 16'h0000);
        check("lk_halt", 24'(cpu_halt), 24'h00_0000);
        check("lk_cfg", 24'(debug_config), 24'(`DBC_CFG_RESET));
        cmd("lk_status", '{8'h34}, 8, st(1'b0));
        cmd("lk_id", '{8'h68}, 16, {`DBC_PART_NUMBER, `DBC_REVISION});
        pq.push_back(6'b10_0000);
        cmd("lk_erase", '{8'h14}, 8, st(1'b0));
        $display("lock test done");
        check("pending", 24'(exp_q.size() + pq.size()), 24'h00_0000);
        conclude();
    end
endmodule
